// ==== design/power_up_reset_sequencer.sv ====
`timescale 1ns/1ps
module power_up_reset_sequencer #(
  parameter int PUT_TICKS = pwr_seq_pkg::POWER_UP_DELAY_TICKS,
  parameter int OST_CYCLES = pwr_seq_pkg::OSC_STARTUP_CYCLES,
  parameter int CNT_W = 17
) (
  input wire logic sys_clk, // 50 MHz system clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic supply_detect, // Supply comparator, high above the detection band
  input wire logic master_clear_n, // Master clear pin, active low
  input wire logic osc_input_pin, // Oscillator input pin
  input wire logic wdt_timeout, // Watchdog time-out pulse
  input wire logic sleep_exec, // Sleep instruction executed pulse
  input wire logic irq_wake, // Interrupt wake-up pulse
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [pwr_seq_pkg::ADR_W-1:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic irq_o, // Level interrupt
  output logic core_reset_n, // Core reset, active low
  output logic core_run, // Core clocked and out of reset
  output pwr_seq_pkg::flags_t status_flags // Reset cause flags
);
  import pwr_seq_pkg::*;

  localparam int DIV_W = $clog2(RC_TICK_CYCLES);

  typedef enum logic [2:0] {ST_OFF, ST_PUT, ST_OST, ST_RUN, ST_SLEEP} state_t;

  // Reset release
  logic [1:0] rst_pipe_reg;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_reg <= 2'b00;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  // Pin synchronisers: a level is accepted once stages two and three agree
  wire logic [PIN_N-1:0] pins;
  wire logic [PIN_N-1:0] lvl;
  assign pins = {osc_input_pin, master_clear_n, supply_detect};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      logic [2:0] s_reg;
      logic lvl_reg;
      logic lvl_next;
      always_comb begin
        lvl_next = (s_reg[1] == s_reg[2]) ? s_reg[2] : lvl_reg;
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s_reg <= 3'h0;
          lvl_reg <= 1'b0;
        end else begin
          s_reg <= {s_reg[1:0], pins[gi]};
          lvl_reg <= lvl_next;
        end
      end
      assign lvl[gi] = lvl_reg;
    end
  endgenerate

  logic [PIN_N-1:0] lvl_d_reg;
  logic supply_rise;
  logic master_clear_n_fall;
  logic osc_rise;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_d_reg <= '0;
    end else begin
      lvl_d_reg <= lvl;
    end
  end

  // Only the rising edge of the supply detector is looked at
  assign supply_rise = lvl[PIN_SUPPLY] & ~lvl_d_reg[PIN_SUPPLY]; // [R1] [R2]
  assign master_clear_n_fall = ~lvl[PIN_MASTER_CLEAR_N] & lvl_d_reg[PIN_MASTER_CLEAR_N];
  assign osc_rise = lvl[PIN_OSC] & ~lvl_d_reg[PIN_OSC];

  // Slow tick standing in for the power-up timer's own RC oscillator
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    tick_next = (div_reg == DIV_W'(RC_TICK_CYCLES - 1));
    div_next = tick_next ? '0 : div_reg + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  // Sequencer
  ctrl_t ctrl_reg;
  state_t state_reg;
  state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  flags_t flags_reg;
  flags_t flags_next;
  logic seq_reset_reg;
  logic seq_reset_next;
  logic [EV_W-1:0] ev;
  logic crystal;
  logic wdt_reset;
  state_t wake_target;

  always_comb begin
    crystal = (ctrl_reg.mode != OSC_RESISTOR_CAP);
    wake_target = crystal ? ST_OST : ST_RUN; // [R7]
    state_next = state_reg;
    cnt_next = cnt_reg;
    flags_next = flags_reg;
    seq_reset_next = seq_reset_reg;
    ev = '0;
    wdt_reset = 1'b0;
    case (state_reg)
      ST_OFF: begin
        state_next = ST_OFF;
      end
      ST_PUT: begin
        if (tick_reg) begin
          if (cnt_reg == CNT_W'(PUT_TICKS - 1)) begin // [R3]
            cnt_next = '0;
            state_next = wake_target; // [R8] [R9]
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end
      ST_OST: begin
        if (osc_rise) begin
          if (cnt_reg == CNT_W'(OST_CYCLES - 1)) begin // [R6]
            cnt_next = '0;
            state_next = ST_RUN;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (master_clear_n_fall) begin
          flags_next = FLAGS_POR; // [R13]
          ev[EV_MASTER_CLEAR_N] = 1'b1;
        end else if (wdt_timeout) begin
          flags_next.timeout = 1'b0; // [R12] [R16]
          flags_next.powerdown = 1'b1; // [R12]
          wdt_reset = 1'b1;
          ev[EV_WDT_RESET] = 1'b1;
        end else if (sleep_exec) begin
          flags_next.powerdown = 1'b0; // [R15]
          flags_next.timeout = 1'b1;
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        cnt_next = '0;
        if (master_clear_n_fall) begin
          flags_next.timeout = 1'b1; // [R14]
          flags_next.powerdown = 1'b0; // [R14]
          seq_reset_next = 1'b1;
          state_next = wake_target;
          ev[EV_MASTER_CLEAR_N] = 1'b1;
        end else if (wdt_timeout) begin
          flags_next.timeout = 1'b0; // [R12] [R16]
          flags_next.powerdown = 1'b0; // [R12]
          seq_reset_next = 1'b0;
          state_next = wake_target; // [R9]
          ev[EV_WAKE] = 1'b1;
        end else if (irq_wake) begin
          flags_next.timeout = 1'b1; // [R14]
          flags_next.powerdown = 1'b0; // [R14]
          seq_reset_next = 1'b0;
          state_next = wake_target;
          ev[EV_WAKE] = 1'b1;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    // Power-on overrides everything, whatever state the supply dip left behind
    if (supply_rise) begin
      flags_next = FLAGS_POR; // [R11] [R15]
      seq_reset_next = 1'b1;
      cnt_next = '0;
      ev = '0;
      ev[EV_POR] = 1'b1;
      wdt_reset = 1'b0;
      if (ctrl_reg.put_en) begin // [R5]
        state_next = ST_PUT; // [R8]
      end else begin
        state_next = wake_target; // [R9]
      end
    end
    if (state_next == ST_RUN && state_reg != ST_RUN) begin
      ev[EV_RELEASE] = 1'b1;
      seq_reset_next = 1'b0;
    end
  end

  // Core reset follows the next state so it lines up with the state register
  logic core_reset_n_next;
  logic core_run_next;
  logic timer_hold;

  always_comb begin
    timer_hold = seq_reset_next & (state_next == ST_PUT || state_next == ST_OST); // [R4]
    // Master clear only adds to the hold; it restarts no timer, save the start-up count when it ends sleep in a crystal mode
    core_reset_n_next = ~(supply_rise | ~lvl[PIN_MASTER_CLEAR_N] | timer_hold | wdt_reset
                          | (state_next == ST_OFF)); // [R17] [R10]
    core_run_next = core_reset_n_next & (state_next == ST_RUN);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
      cnt_reg <= '0;
      flags_reg <= FLAGS_POR;
      seq_reset_reg <= 1'b1;
      core_reset_n <= 1'b0;
      core_run <= 1'b0;
      status_flags <= FLAGS_POR;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      flags_reg <= flags_next;
      seq_reset_reg <= seq_reset_next;
      core_reset_n <= core_reset_n_next;
      core_run <= core_run_next;
      status_flags <= flags_next;
    end
  end

  // Wishbone slave, one wait state, unmapped reads return zero
  logic ack_next;
  logic [31:0] dat_next;
  ctrl_t ctrl_next;
  logic [EV_W-1:0] ist_reg;
  logic [EV_W-1:0] ist_next;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] mask_next;
  logic irq_next;
  logic hit;
  logic wr;
  logic [STAT_W-1:0] stat_view;

  always_comb begin
    hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr = hit & wb_we_i & wb_sel_i[0];
    ack_next = hit;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    ist_next = ist_reg;
    dat_next = wb_dat_o;
    stat_view = {state_reg == ST_SLEEP, ~core_reset_n, flags_reg};
    if (wr && wb_adr_i == CTRL_OFS) begin
      ctrl_next = ctrl_t'(wb_dat_i[CTRL_W-1:0]);
    end
    if (wr && wb_adr_i == IRQ_MASK_OFS) begin
      mask_next = wb_dat_i[EV_W-1:0];
    end
    if (wr && wb_adr_i == IRQ_STAT_OFS) begin
      ist_next = ist_reg & ~wb_dat_i[EV_W-1:0];
    end
    // A new event wins over a clear in the same cycle
    ist_next = ist_next | ev;
    if (hit) begin
      case (wb_adr_i)
        CTRL_OFS: dat_next = 32'(ctrl_reg);
        STAT_OFS: dat_next = 32'(stat_view);
        IRQ_STAT_OFS: dat_next = 32'(ist_reg);
        IRQ_MASK_OFS: dat_next = 32'(mask_reg);
        default: dat_next = 32'h0000_0000;
      endcase
    end
    irq_next = |(ist_next & mask_next);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= '0;
      ist_reg <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      ist_reg <= ist_next;
      wb_ack_o <= ack_next;
      wb_dat_o <= dat_next;
      irq_o <= irq_next;
    end
  end

  // Helper counters for the checks below
  logic [CNT_W:0] put_seen_reg;
  logic [CNT_W:0] ost_seen_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      put_seen_reg <= '0;
      ost_seen_reg <= '0;
    end else begin
      put_seen_reg <= (state_reg != ST_PUT) ? '0 : put_seen_reg + (CNT_W + 1)'(tick_reg);
      ost_seen_reg <= (state_reg != ST_OST) ? '0 : ost_seen_reg + (CNT_W + 1)'(osc_rise);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence put_ends;
    state_reg == ST_PUT && state_next != ST_PUT && !supply_rise;
  endsequence

  sequence ost_ends;
    state_reg == ST_OST && state_next != ST_OST && !supply_rise;
  endsequence

  chk_por_flags_set: assert property ( // [R11]
    supply_rise |=> status_flags == FLAGS_POR && core_reset_n == 1'b0)
    else $error("power-on did not set both flags or hold reset");

  chk_fall_no_reset: assert property ( // [R2]
    $fell(lvl[PIN_SUPPLY]) && state_reg == ST_RUN |=> state_reg == ST_RUN || state_reg == ST_SLEEP)
    else $error("falling supply restarted the sequence");

  chk_put_holds_core: assert property ( // [R4]
    state_reg == ST_PUT |-> !core_reset_n)
    else $error("core left reset while power-up timer ran");

  chk_put_enable_bit: assert property ( // [R5]
    supply_rise && !ctrl_reg.put_en |=> state_reg != ST_PUT)
    else $error("power-up timer ran while disabled");

  chk_put_length: assert property ( // [R3]
    put_ends |-> put_seen_reg + (CNT_W + 1)'(tick_reg) == (CNT_W + 1)'(PUT_TICKS))
    else $error("power-up delay length wrong");

  chk_ost_length: assert property ( // [R6]
    ost_ends |-> ost_seen_reg + (CNT_W + 1)'(osc_rise) == (CNT_W + 1)'(OST_CYCLES))
    else $error("start-up count length wrong");

  chk_seq_order: assert property ( // [R8]
    put_ends |=> state_reg == ($past(crystal) ? ST_OST : ST_RUN))
    else $error("start-up timer did not follow power-up timer");

  chk_ost_mode_only: assert property ( // [R7]
    $rose(state_reg == ST_OST) |-> $past(crystal))
    else $error("start-up timer ran in RC mode");

  chk_master_clear_n_holds: assert property ( // [R17]
    !lvl[PIN_MASTER_CLEAR_N] |=> !core_reset_n)
    else $error("master clear low did not hold reset");

  chk_master_clear_n_release: assert property ( // [R10]
    $rose(lvl[PIN_MASTER_CLEAR_N]) && state_reg == ST_RUN && !wdt_timeout && !supply_rise |=> core_reset_n)
    else $error("release after expired time-outs was delayed");

  chk_wdt_run_flags: assert property ( // [R12]
    state_reg == ST_RUN && wdt_timeout && !master_clear_n_fall && !supply_rise
    |=> !status_flags.timeout && status_flags.powerdown && !core_reset_n)
    else $error("watchdog reset flags wrong");

  chk_sleep_clears_pd: assert property ( // [R15]
    state_reg == ST_RUN && sleep_exec && !wdt_timeout && !master_clear_n_fall && !supply_rise
    |=> state_reg == ST_SLEEP && !status_flags.powerdown && status_flags.timeout)
    else $error("sleep did not clear powerdown flag");

  chk_int_wake_flags: assert property ( // [R14]
    state_reg == ST_SLEEP && irq_wake && !wdt_timeout && !master_clear_n_fall && !supply_rise
    |=> status_flags.timeout && !status_flags.powerdown)
    else $error("interrupt wake-up flags wrong");
endmodule : power_up_reset_sequencer

// ==== design/pwr_seq_pkg.sv ====
// Behaviour
// R1 - A rising supply through the detection band produces one internal power-on pulse.
// R2 - A falling supply never produces an internal reset.
// R3 - After the power-on pulse the power-up timer runs a fixed 72 ms on its own slow tick.
// R4 - The core stays in reset for as long as the power-up timer runs.
// R5 - The power_up_timer_enable bit decides whether the power-up delay is applied.
// R6 - After the power-up delay the start-up timer counts 1024 oscillator input cycles.
// R7 - The start-up count runs only in the three crystal modes and only on power-on or wake-up.
// R8 - Power-up runs the power-up timer first and then the start-up timer.
// R9 - Crystal modes wait delay plus 1024 cycles, or 1024 alone; RC mode waits the delay or none.
// R10 - Time-outs run from the power-on pulse regardless of master clear; release then runs at once.
// R11 - After power-on both timeout_flag and powerdown_flag read 1.
// R12 - Watchdog reset in run gives timeout 0, powerdown 1; watchdog wake-up gives both 0.
// R13 - Master clear in normal operation leaves both flags at 1.
// R14 - Master clear in sleep or an interrupt wake-up gives timeout 1 and powerdown 0.
// R15 - The powerdown_flag is set on power-up and cleared by the sleep instruction.
// R16 - The timeout_flag is cleared whenever the watchdog times out; the code ignores a time-out outside run and sleep.
// R17 - Core reset is held during the power-on pulse, master clear low, or either timer running; the code skips the hold on a watchdog or interrupt wake.
package pwr_seq_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RC_TICK_NS = 1000;
  localparam int RC_TICK_CYCLES = (RC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_UP_DELAY_MS = 72;
  localparam int POWER_UP_DELAY_TICKS = (POWER_UP_DELAY_MS * 1_000_000) / RC_TICK_NS;
  localparam int OSC_STARTUP_CYCLES = 1024;

  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADR_W-1:0] STAT_OFS = 8'h04;
  localparam logic [ADR_W-1:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [ADR_W-1:0] IRQ_MASK_OFS = 8'h0c;

  localparam int PIN_SUPPLY = 0;
  localparam int PIN_MASTER_CLEAR_N = 1;
  localparam int PIN_OSC = 2;
  localparam int PIN_N = 3;

  localparam int EV_POR = 0;
  localparam int EV_WDT_RESET = 1;
  localparam int EV_MASTER_CLEAR_N = 2;
  localparam int EV_WAKE = 3;
  localparam int EV_RELEASE = 4;
  localparam int EV_W = 5;

  localparam int CTRL_W = 3;
  localparam int STAT_W = 4;

  typedef enum logic [1:0] {
    OSC_LOW_POWER_CRYSTAL = 2'h0,
    OSC_CRYSTAL_STD = 2'h1,
    OSC_HIGH_SPEED_CRYSTAL = 2'h2,
    OSC_RESISTOR_CAP = 2'h3
  } osc_mode_t;

  // Bit 0 enables the power-up timer, bits 2:1 select the oscillator mode
  typedef struct packed {
    osc_mode_t mode;
    logic put_en;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{mode: OSC_CRYSTAL_STD, put_en: 1'b1};

  typedef struct packed {
    logic powerdown;
    logic timeout;
  } flags_t;

  localparam flags_t FLAGS_POR = '{powerdown: 1'b1, timeout: 1'b1};
endpackage : pwr_seq_pkg

// ==== dv/osc_master_clear_n_model.sv ====
`timescale 1ns/1ps
module osc_master_clear_n_model #(
  parameter int HALF = 4
) (
  input wire logic sys_clk, // Bench clock
  input wire logic osc_run, // Crystal powered
  input wire logic hold_low, // Reset switch pressed
  output logic master_clear_n, // Pin with pull-up
  output logic osc_input_pin // Crystal output
);
  int cnt = 0;
  initial osc_input_pin = 1'b0;
  // Pull-up wins whenever the switch is open
  assign master_clear_n = hold_low ? 1'b0 : 1'b1;
  // Levels last HALF cycles so the design's 3-flop sync sees every edge
  always @(posedge sys_clk) begin
    if (osc_run && cnt == HALF - 1) begin
      cnt <= 0;
      osc_input_pin <= ~osc_input_pin;
    end else begin
      cnt <= osc_run ? cnt + 1 : 0;
    end
  end
endmodule : osc_master_clear_n_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import pwr_seq_pkg::*;
  typedef struct {logic [2:0] ctrl; int lo; int hi;} row_t;
  logic sys_clk = 1'b0, rst_b = 1'b0, supply_detect = 1'b0, hold_low = 1'b0;
  logic [2:0] pls = 3'h0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, rd;
  logic master_clear_n, osc_input_pin, wb_ack, irq, core_reset_n, core_run;
  flags_t status_flags;
  int num_errors = 0, total_checks = 0, n;
  row_t rows[8];

  osc_master_clear_n_model #(.HALF(4)) u_model (.sys_clk(sys_clk), .osc_run(supply_detect),
    .hold_low(hold_low), .master_clear_n(master_clear_n), .osc_input_pin(osc_input_pin));

  // Short counts: 20 ticks of 50 cycles, 8 oscillator edges
  power_up_reset_sequencer #(.PUT_TICKS(20), .OST_CYCLES(8)) u_dut (.sys_clk(sys_clk),
    .rst_b(rst_b), .supply_detect(supply_detect), .master_clear_n(master_clear_n),
    .osc_input_pin(osc_input_pin), .wdt_timeout(pls[0]), .sleep_exec(pls[1]),
    .irq_wake(pls[2]), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_sel_i(wb_sel), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack), .irq_o(irq), .core_reset_n(core_reset_n), .core_run(core_run),
    .status_flags(status_flags));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat} <= {2'b11, we, 4'hf, a, d};
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    if (k >= 20) check("bus ack", 0, 1);
    rd = wb_dat_o;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
  endtask : wb_xfer

  task automatic pulse(input int k);
    @(posedge sys_clk);
    pls <= 3'h1 << k;
    @(posedge sys_clk);
    pls <= 3'h0;
  endtask : pulse

  task automatic wait_up(input bit run, output int c);
    c = 0;
    while ((run ? core_run : core_reset_n) !== 1'b1 && c < 3000) begin
      @(posedge sys_clk);
      c++;
    end
    // A hang here must fail the run even where the caller only waits
    if (c >= 3000) check("wait limit", 0, 1);
  endtask : wait_up

  task automatic settle_flags(input string name, input logic [1:0] exp);
    repeat (6) @(negedge sys_clk);
    check(name, 32'(status_flags), 32'(exp));
  endtask : settle_flags

  task automatic do_reset;
    @(posedge sys_clk);
    {rst_b, supply_detect} <= 2'b00;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset

  initial begin
    repeat (40000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end

  initial begin
    rows = '{'{3'h1, 990, 1120}, '{3'h0, 40, 110}, '{3'h3, 990, 1120},
      '{3'h5, 990, 1120}, '{3'h4, 40, 110}, '{3'h7, 940, 1020}, '{3'h6, 0, 15},
      '{3'h2, 40, 110}};
    do_reset();
    wb_xfer(0, CTRL_OFS, 0);
    check("ctrl reset", rd, 32'h3);
    wb_xfer(0, IRQ_MASK_OFS, 0);
    check("mask reset", rd, 0);
    foreach (rows[i]) begin
      do_reset();
      wb_xfer(1, CTRL_OFS, 32'(rows[i].ctrl));
      @(posedge sys_clk);
      supply_detect <= 1'b1;
      wait_up(0, n);
      check("release window", 32'(n >= rows[i].lo && n <= rows[i].hi), 1);
      check("flags power-on", 32'(status_flags), 32'h3);
    end
    // Crystal mode, timer off, now running
    wait_up(1, n);
    wb_xfer(1, IRQ_STAT_OFS, 32'h1f);
    wb_xfer(1, IRQ_MASK_OFS, 32'h2);
    check("irq idle", 32'(irq), 0);
    pulse(2);
    settle_flags("irq wake in run", 2'b11);
    pulse(0);
    n = 0;
    repeat (8) begin
      @(negedge sys_clk);
      n += (core_reset_n === 1'b0);
    end
    check("wdt reset width", n, 1);
    check("flags wdt run", 32'(status_flags), 32'h2);
    check("irq raised", 32'(irq), 1);
    wb_xfer(1, IRQ_STAT_OFS, 32'h2);
    @(negedge sys_clk);
    check("irq cleared", 32'(irq), 0);
    wb_xfer(0, 8'h10, 0);
    check("unmapped read", rd, 0);
    wb_xfer(1, STAT_OFS, 32'hf);
    wb_xfer(0, STAT_OFS, 0);
    check("status ro", rd & 32'h3, 32'h2);
    wait_up(1, n);
    pulse(1);
    settle_flags("flags sleep", 2'b01);
    pulse(0);
    settle_flags("flags wdt wake", 2'b00);
    wait_up(1, n);
    check("wake start-up", 32'(n >= 30), 1);
    pulse(1);
    pulse(2);
    settle_flags("flags irq wake", 2'b01);
    wait_up(1, n);
    @(posedge sys_clk);
    hold_low <= 1'b1;
    settle_flags("flags master_clear_n run", 2'b11);
    check("held by pin", 32'(core_reset_n), 0);
    @(posedge sys_clk);
    hold_low <= 1'b0;
    wait_up(0, n);
    check("master_clear_n release", 32'(n <= 12), 1);
    wait_up(1, n);
    pulse(1);
    @(posedge sys_clk);
    hold_low <= 1'b1;
    settle_flags("flags master_clear_n sleep", 2'b01);
    @(posedge sys_clk);
    hold_low <= 1'b0;
    wait_up(1, n);
    @(posedge sys_clk);
    supply_detect <= 1'b0;
    repeat (20) @(negedge sys_clk);
    check("supply fall", 32'(core_reset_n), 1);
    // Timer on so the pin has to outlast both the power-up and start-up counts
    wb_xfer(1, CTRL_OFS, 32'h3);
    @(posedge sys_clk);
    {hold_low, supply_detect} <= 2'b11;
    repeat (1200) @(negedge sys_clk);
    check("pin extends", 32'(core_reset_n), 0);
    @(posedge sys_clk);
    hold_low <= 1'b0;
    wait_up(0, n);
    check("expired at release", 32'(n <= 12), 1);
    check("flags second power-on", 32'(status_flags), 32'h3);
    complete_run();
  end
endmodule : tb_top
